//--- design/cln_writer.sv
// write-only 4-bit parallel driver for a character lcd module
// assumes synchronous inputs on clk_sys and the lcd r/w pin grounded
`timescale 1ns/1ps
`default_nettype none
module cln_writer #(
	parameter int LINES = 2,
	parameter int LINE_LENGTH = 20,
	parameter int FIFO_DEPTH = cln_pkg::FIFO_DEPTH_DEF,
	parameter int POWER_CYC = cln_pkg::POWER_CYC,
	parameter int WAKE_CYC = cln_pkg::WAKE_CYC,
	parameter int SHORT_CYC = cln_pkg::SHORT_CYC,
	parameter int CLEAR_CYC = cln_pkg::CLEAR_CYC
)(
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic              cmdValid,
	output logic                   cmdReady,
	input  wire cln_pkg::cln_cmd_t cmd,
	input  wire logic              byteValid,
	output logic                   byteReady,
	input  wire logic [7:0]        byteData,
	output cln_pkg::cln_pins_t     pins,
	output logic [5:0]             pinOe,
	output logic                   initDone,
	output logic                   cmdRefused
);
	if (!(LINES == 1 || LINES == 2 || LINES == 4) || LINE_LENGTH < 1
		|| LINE_LENGTH > 40 || POWER_CYC < 1 || WAKE_CYC < 1
		|| SHORT_CYC < 1 || CLEAR_CYC < 1)
	begin : g_bad
		$error("unsupported line count, length or delay");
	end

	typedef enum {
		ST_IDLE, ST_POWER, ST_INIT, ST_WORK, ST_NSETUP,
		ST_NHIGH, ST_NGAP, ST_WAIT, ST_DRAIN
	} cln_state_t;

	cln_state_t        state, next_state, ret, next_ret;
	cln_pkg::cln_cmd_t cur, next_cur;
	cln_pkg::cln_pins_t next_pins;
	cln_pkg::cln_init_t step;
	logic [5:0]        next_pinOe;
	logic              next_initDone, next_cmdRefused;
	logic [31:0]       timer, next_timer, execDly, next_execDly;
	logic [7:0]        shift, next_shift, remain, next_remain;
	logic [7:0]        blankLeft, next_blankLeft, width, start;
	logic              rsBit, next_rsBit, twoNib, next_twoNib;
	logic [1:0]        phase, next_phase;
	logic [3:0]        idx, next_idx;
	logic              sendReq, sendRs, sendNibOnly, accept, fifoPop;
	logic [7:0]        sendByte;
	logic [31:0]       sendDly;
	logic              fifoValid;
	logic [7:0]        fifoData;

	// ==========================================================
	// helpers
	function automatic logic [6:0] lineBase(input logic [2:0] n);
		unique case (n)
			3'h2: return cln_pkg::LINE2_BASE;
			3'h3: return 7'(LINE_LENGTH);
			3'h4: return cln_pkg::LINE2_BASE + 7'(LINE_LENGTH);
			default: return 7'h00;
		endcase
	endfunction

	function automatic logic [7:0] centreWidth(
		input cln_pkg::cln_centre_t c);
		unique case (c)
			cln_pkg::CENTRE_WIDTH_8: return 8'h08;
			cln_pkg::CENTRE_WIDTH_16: return 8'h10;
			cln_pkg::CENTRE_WIDTH_20: return 8'h14;
			cln_pkg::CENTRE_WIDTH_40: return 8'h28;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [31:0] delayCycles(
		input cln_pkg::cln_delay_t d);
		unique case (d)
			cln_pkg::DLY_SHORT: return 32'(SHORT_CYC);
			cln_pkg::DLY_WAKE: return 32'(WAKE_CYC);
			cln_pkg::DLY_CLEAR: return 32'(CLEAR_CYC);
			default: return 32'(cln_pkg::EXEC_CYC);
		endcase
	endfunction

	// 8-bit wake nibbles, switch to 4-bit, then the usual setup bytes
	function automatic cln_pkg::cln_init_t initStep(input logic [3:0] i);
		logic [7:0] funcSet;
		funcSet = cln_pkg::INSTR_FUNC_4BIT
			| ((LINES == 1) ? 8'h00 : cln_pkg::FUNC_MULTI_LINE);
		unique case (i)
			4'h0: return '{1'b1, cln_pkg::NIB_WAKE, cln_pkg::DLY_WAKE};
			4'h1: return '{1'b1, cln_pkg::NIB_WAKE, cln_pkg::DLY_SHORT};
			4'h2: return '{1'b1, cln_pkg::NIB_WAKE, cln_pkg::DLY_EXEC};
			4'h3: return '{1'b1, cln_pkg::NIB_4BIT, cln_pkg::DLY_EXEC};
			4'h4: return '{1'b0, funcSet, cln_pkg::DLY_EXEC};
			4'h5: return '{1'b0, cln_pkg::INSTR_DISPLAY_ON,
				cln_pkg::DLY_EXEC};
			4'h6: return '{1'b0, cln_pkg::INSTR_CLEAR, cln_pkg::DLY_CLEAR};
			default: return '{1'b0, cln_pkg::INSTR_ENTRY,
				cln_pkg::DLY_EXEC};
		endcase
	endfunction

	function automatic logic badText(input cln_pkg::cln_cmd_t c);
		return c.op == cln_pkg::OP_TEXT && (c.lineNo == 3'h0
			|| 32'(c.lineNo) > 32'(LINES)
			|| (c.centre == cln_pkg::CENTRE_NONE && c.pos == 7'h00));
	endfunction

	// ==========================================================
	// byte fifo; caller pushes raw or text bytes ahead of the command
	cln_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.inValid  (byteValid),
		.inReady  (byteReady),
		.inData   (byteData),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData)
	);

	assign accept = cmdValid && cmdReady;
	assign step = initStep(idx);
	assign width = centreWidth(cur.centre);
	assign start = (cur.centre == cln_pkg::CENTRE_NONE)
		? {1'b0, cur.pos} - 8'h01
		: ((cur.count < width) ? ((width - cur.count) >> 1) : 8'h00);

	// ==========================================================
	// sequencer
	always_comb
	begin
		next_state = state;
		next_ret = ret;
		next_cur = cur;
		next_pins = pins;
		next_pinOe = pinOe;
		next_initDone = initDone;
		next_cmdRefused = 1'b0;
		next_timer = timer;
		next_execDly = execDly;
		next_shift = shift;
		next_remain = remain;
		next_blankLeft = blankLeft;
		next_rsBit = rsBit;
		next_twoNib = twoNib;
		next_phase = phase;
		next_idx = idx;
		sendReq = 1'b0;
		sendRs = 1'b0;
		sendNibOnly = 1'b0;
		sendByte = 8'h00;
		sendDly = 32'(cln_pkg::EXEC_CYC);
		fifoPop = 1'b0;
		unique case (state)
			ST_IDLE:
				if (accept)
				begin
					next_cur = cmd;
					if (cmd.op == cln_pkg::OP_DISPLAY_SETUP)
					begin
						next_pinOe = cln_pkg::PIN_ALL_OUT;
						next_pins = '0;
						next_initDone = 1'b0;
						next_idx = 4'h0;
						next_timer = 32'(POWER_CYC) - 32'h1;
						next_state = ST_POWER;
					end
					else if (cmd.op == cln_pkg::OP_DISPLAY_RELEASE)
					begin
						next_pinOe = 6'h00;
						next_pins = '0;
						next_initDone = 1'b0;
					end
					else if (!initDone || badText(cmd))
					begin
						// refused bytes are discarded so the stream stays aligned
						next_cmdRefused = 1'b1;
						next_remain = cmd.count;
						if (cmd.op != cln_pkg::OP_DISPLAY_BLANK)
							next_state = ST_DRAIN;
					end
					else
					begin
						next_remain = (cmd.op == cln_pkg::OP_DISPLAY_BLANK)
							? 8'h00 : cmd.count;
						next_blankLeft = centreWidth(cmd.centre);
						if (cmd.op == cln_pkg::OP_TEXT)
							next_phase = (cmd.centre == cln_pkg::CENTRE_NONE)
								? 2'h2 : 2'h0;
						else
							next_phase = (cmd.op == cln_pkg::OP_DISPLAY_BLANK)
								? 2'h0 : 2'h3;
						next_state = ST_WORK;
					end
				end
			ST_POWER:
				if (timer == 32'h0)
					next_state = ST_INIT;
				else
					next_timer = timer - 32'h1;
			ST_INIT:
				if (idx == cln_pkg::INIT_STEPS)
				begin
					next_initDone = 1'b1;
					next_state = ST_IDLE;
				end
				else
				begin
					sendReq = 1'b1;
					sendNibOnly = step.nibOnly;
					sendByte = step.value;
					sendDly = delayCycles(step.dly);
					next_idx = idx + 4'h1;
				end
			ST_WORK:
				unique case (phase)
					2'h0:
					begin
						sendReq = 1'b1;
						if (cur.op == cln_pkg::OP_DISPLAY_BLANK)
						begin
							sendByte = cln_pkg::INSTR_CLEAR;
							sendDly = 32'(CLEAR_CYC);
							next_phase = 2'h3;
						end
						else
						begin
							sendByte = cln_pkg::INSTR_SET_ADDR
								| {1'b0, lineBase(cur.lineNo)};
							next_phase = 2'h1;
						end
					end
					2'h1:
						if (blankLeft == 8'h00)
							next_phase = 2'h2;
						else
						begin
							sendReq = 1'b1;
							sendRs = 1'b1;
							sendByte = cln_pkg::SPACE_CHAR;
							next_blankLeft = blankLeft - 8'h01;
						end
					2'h2:
					begin
						sendReq = 1'b1;
						sendByte = cln_pkg::INSTR_SET_ADDR
							| {1'b0, lineBase(cur.lineNo) + start[6:0]};
						next_phase = 2'h3;
					end
					default:
						if (remain == 8'h00)
							next_state = ST_IDLE;
						else if (fifoValid)
						begin
							fifoPop = 1'b1;
							sendReq = 1'b1;
							sendRs = cur.op != cln_pkg::OP_RAW_INSTRUCTION;
							sendByte = fifoData;
							next_remain = remain - 8'h01;
						end
				endcase
			ST_NSETUP:
				if (timer == 32'h0)
				begin
					next_pins.enableLine = 1'b1;
					next_timer = 32'(cln_pkg::PULSE_CYC) - 32'h1;
					next_state = ST_NHIGH;
				end
				else
					next_timer = timer - 32'h1;
			ST_NHIGH:
				if (timer == 32'h0)
				begin
					next_pins.enableLine = 1'b0;
					next_timer = 32'(cln_pkg::GAP_CYC) - 32'h1;
					next_state = ST_NGAP;
				end
				else
					next_timer = timer - 32'h1;
			ST_NGAP:
				if (timer != 32'h0)
					next_timer = timer - 32'h1;
				else if (twoNib)
				begin
					next_twoNib = 1'b0;
					next_pins.nibbleLine = shift[3:0];
					next_timer = 32'(cln_pkg::SETUP_CYC) - 32'h1;
					next_state = ST_NSETUP;
				end
				else
				begin
					// status is never read, so every byte waits its worst case
					next_timer = execDly - 32'h1;
					next_state = ST_WAIT;
				end
			ST_WAIT:
				if (timer == 32'h0)
					next_state = ret;
				else
					next_timer = timer - 32'h1;
			ST_DRAIN:
				if (remain == 8'h00)
					next_state = ST_IDLE;
				else if (fifoValid)
				begin
					fifoPop = 1'b1;
					next_remain = remain - 8'h01;
				end
		endcase
		if (sendReq)
		begin
			next_shift = sendByte;
			next_rsBit = sendRs;
			next_twoNib = !sendNibOnly;
			next_execDly = sendDly;
			next_ret = state;
			next_pins = '{sendByte[7:4], sendRs, 1'b0};
			next_timer = 32'(cln_pkg::SETUP_CYC) - 32'h1;
			next_state = ST_NSETUP;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state <= ST_IDLE;
			ret <= ST_IDLE;
			cur <= '0;
			pins <= '0;
			pinOe <= 6'h00;
			initDone <= 1'b0;
			cmdRefused <= 1'b0;
			cmdReady <= 1'b1;
			timer <= 32'h0;
			execDly <= 32'h0;
			shift <= 8'h00;
			remain <= 8'h00;
			blankLeft <= 8'h00;
			rsBit <= 1'b0;
			twoNib <= 1'b0;
			phase <= 2'h0;
			idx <= 4'h0;
		end
		else
		begin
			state <= next_state;
			ret <= next_ret;
			cur <= next_cur;
			pins <= next_pins;
			pinOe <= next_pinOe;
			initDone <= next_initDone;
			cmdRefused <= next_cmdRefused;
			cmdReady <= next_state == ST_IDLE;
			timer <= next_timer;
			execDly <= next_execDly;
			shift <= next_shift;
			remain <= next_remain;
			blankLeft <= next_blankLeft;
			rsBit <= next_rsBit;
			twoNib <= next_twoNib;
			phase <= next_phase;
			idx <= next_idx;
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	chk_oe_before_strobe: assert property (pins.enableLine
		|-> pinOe == cln_pkg::PIN_ALL_OUT) else $error("strobe unconfigured");
	chk_strobe_after_init: assert property (pins.enableLine
		|-> initDone || ret == ST_INIT) else $error("strobe before setup");
	chk_select_steady: assert property (
		pins.enableLine && $past(pins.enableLine) |-> $stable(pins.regSelectLine))
		else $error("select moved during strobe");
	chk_nibble_steady: assert property (
		pins.enableLine && $past(pins.enableLine) |-> $stable(pins.nibbleLine))
		else $error("data moved during strobe");
	chk_pulse_width: assert property ($rose(pins.enableLine)
		|-> pins.enableLine [*8]) else $error("strobe too short");
	chk_nibble_gap: assert property ($fell(pins.enableLine)
		|-> !pins.enableLine [*8]) else $error("strobes too close");
	chk_release_pins: assert property (accept
		&& cmd.op == cln_pkg::OP_DISPLAY_RELEASE
		|=> pinOe == 6'h00 && !initDone ##1 !pins.enableLine)
		else $error("release left pins configured");
	chk_refuse_early: assert property (accept && !initDone
		&& cmd.op == cln_pkg::OP_RAW_CHAR |=> cmdRefused && !pins.enableLine)
		else $error("raw request before setup not refused");
	chk_bad_line: assert property (accept && initDone
		&& cmd.op == cln_pkg::OP_TEXT && cmd.lineNo == 3'h0 |=> cmdRefused)
		else $error("line zero accepted");
	chk_blank_starts: assert property (accept && initDone
		&& cmd.op == cln_pkg::OP_DISPLAY_BLANK |-> ##2 pins.nibbleLine == 4'h0
		&& !pins.regSelectLine) else $error("clear not started");
	chk_char_select: assert property (pins.enableLine && phase == 2'h3
		&& cur.op == cln_pkg::OP_RAW_CHAR && state == ST_NHIGH
		|-> pins.regSelectLine) else $error("char sent as instruction");

	cov_setup_done: cover property ($rose(initDone));
	cov_centred_text: cover property (accept && initDone
		&& cmd.op == cln_pkg::OP_TEXT && cmd.centre != cln_pkg::CENTRE_NONE);
	cov_refused: cover property (cmdRefused);
	cov_fifo_full: cover property (!byteReady);
endmodule
`default_nettype wire

//--- design/cln_pkg.sv
// constants, timing figures and carrier types of the nibble lcd writer
// assumes a single 100 MHz system clock; all counts derive from it
package cln_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_SETUP_NS = 60;
	localparam int T_PULSE_NS = 450;
	localparam int T_GAP_NS = 1000;
	localparam int T_EXEC_NS = 40000;
	localparam int T_SHORT_NS = 100000;
	localparam int T_WAKE_NS = 4100000;
	localparam int T_CLEAR_NS = 1640000;
	localparam int T_POWER_NS = 15000000;

	// least times round up to whole cycles
	function automatic int cycUp(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SETUP_CYC = cycUp(T_SETUP_NS);
	localparam int PULSE_CYC = cycUp(T_PULSE_NS);
	localparam int GAP_CYC = cycUp(T_GAP_NS);
	localparam int EXEC_CYC = cycUp(T_EXEC_NS);
	localparam int SHORT_CYC = cycUp(T_SHORT_NS);
	localparam int WAKE_CYC = cycUp(T_WAKE_NS);
	localparam int CLEAR_CYC = cycUp(T_CLEAR_NS);
	localparam int POWER_CYC = cycUp(T_POWER_NS);

	// ==========================================================
	// display instruction codes and other constants
	localparam logic [7:0] INSTR_CLEAR = 8'h01;
	localparam logic [7:0] INSTR_ENTRY = 8'h06;
	localparam logic [7:0] INSTR_DISPLAY_ON = 8'h0c;
	localparam logic [7:0] INSTR_FUNC_4BIT = 8'h20;
	localparam logic [7:0] FUNC_MULTI_LINE = 8'h08;
	localparam logic [7:0] INSTR_SET_ADDR = 8'h80;
	localparam logic [7:0] NIB_WAKE = 8'h30;
	localparam logic [7:0] NIB_4BIT = 8'h20;
	localparam logic [7:0] SPACE_CHAR = 8'h20;
	localparam logic [6:0] LINE2_BASE = 7'h40;
	localparam logic [3:0] INIT_STEPS = 4'h8;
	localparam logic [5:0] PIN_ALL_OUT = 6'h3f;
	localparam int FIFO_DEPTH_DEF = 8;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		OP_DISPLAY_SETUP,
		OP_RAW_INSTRUCTION,
		OP_RAW_CHAR,
		OP_TEXT,
		OP_DISPLAY_BLANK,
		OP_DISPLAY_RELEASE
	} cln_op_t;

	typedef enum logic [2:0] {
		CENTRE_NONE,
		CENTRE_WIDTH_8,
		CENTRE_WIDTH_16,
		CENTRE_WIDTH_20,
		CENTRE_WIDTH_40
	} cln_centre_t;

	typedef enum logic [1:0] {
		DLY_EXEC,
		DLY_SHORT,
		DLY_WAKE,
		DLY_CLEAR
	} cln_delay_t;

	typedef struct packed {
		cln_op_t     op;
		logic [2:0]  lineNo;
		logic [6:0]  pos;
		cln_centre_t centre;
		logic [7:0]  count;
	} cln_cmd_t;

	typedef struct packed {
		logic [3:0] nibbleLine;
		logic       regSelectLine;
		logic       enableLine;
	} cln_pins_t;

	typedef struct packed {
		logic       nibOnly;
		logic [7:0] value;
		cln_delay_t dly;
	} cln_init_t;

endpackage

//--- design/cln_fifo.sv
// byte fifo between the caller and the nibble sequencer
// assumes one clock; inReady and outValid are registered
`timescale 1ns/1ps
`default_nettype none
module cln_fifo #(
	parameter int W = 8,
	parameter int D = 8
)(
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	if (D < 2 || (1 << AW) != D || W < 1)
	begin : g_bad
		$error("fifo depth must be a power of two of at least 2");
	end

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0]   count;
	logic [AW-1:0] next_wrPtr;
	logic [AW-1:0] next_rdPtr;
	logic [AW:0]   next_count;
	logic          push;
	logic          pop;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr];

	// ==========================================================
	// pointers and level
	always_comb
	begin
		next_wrPtr = wrPtr + AW'(push);
		next_rdPtr = rdPtr + AW'(pop);
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			inReady <= 1'b1;
			outValid <= 1'b0;
		end
		else
		begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			inReady <= next_count != (AW+1)'(D);
			outValid <= next_count != '0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wrPtr] <= inData;
	end

	// ==========================================================
	// checks
	chk_fifo_no_overrun: assert property (@(posedge clk_sys) disable iff (srst)
		count == (AW+1)'(D) |-> !inReady)
		else $error("fifo accepts while full");
	chk_fifo_level: assert property (@(posedge clk_sys) disable iff (srst)
		push && !pop |=> count == $past(count) + (AW+1)'(1))
		else $error("fifo level did not follow a push");
endmodule
`default_nettype wire

//--- testbench/cln_lcd_model.sv
// behavioural character lcd module seen through its 4-bit write port
// assumes r/w grounded; reports each latched transfer as one event
`timescale 1ns/1ps
`default_nettype none
module cln_lcd_model (
	input  wire logic               clk_sys,
	input  wire logic               srst,
	input  wire cln_pkg::cln_pins_t pins,
	input  wire logic [5:0]         pinOe,
	output logic                    evValid,
	output logic                    evRs,
	output logic [7:0]              evData,
	output logic                    protErr
);
	// ==========================================================
	// latch on the rising strobe, report on the falling one, pair nibbles after the first four
	logic       prevEn;
	logic [3:0] hiNib;
	logic [3:0] latNib;
	logic       latRs;
	int         nibCnt;

	always_ff @(posedge clk_sys)
	begin
		evValid <= 1'b0;
		protErr <= 1'b0;
		prevEn <= pins.enableLine;
		if (srst || pinOe !== cln_pkg::PIN_ALL_OUT)
		begin
			nibCnt <= 0;
			// a strobe on an unconfigured port is never latched
			if (!srst && pins.enableLine === 1'b1)
				protErr <= 1'b1;
		end
		else
		begin
			if (pins.enableLine && !prevEn)
			begin
				latNib <= pins.nibbleLine;
				latRs <= pins.regSelectLine;
			end
			if (pins.enableLine && prevEn && (pins.nibbleLine !== latNib
			    || pins.regSelectLine !== latRs))
				protErr <= 1'b1;
			if (!pins.enableLine && prevEn)
			begin
				nibCnt <= nibCnt + 1;
				if (nibCnt < 4)
				begin
					evValid <= 1'b1;
					evRs <= latRs;
					evData <= {latNib, 4'h0};
				end
				else if (nibCnt[0] == 1'b0)
					hiNib <= latNib;
				else
				begin
					evValid <= 1'b1;
					evRs <= latRs;
					evData <= {hiNib, latNib};
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/test_cln_writer.sv
// self-checking bench: lcd writer against the lcd module model
// assumes shortened power-up and clear waits set by parameter
`timescale 1ns/1ps
`default_nettype none
module test_cln_writer;
	logic               clk_sys = 1'b0;
	logic               srst = 1'b1;
	logic               cmdValid = 1'b0;
	logic               byteValid = 1'b0;
	logic [7:0]         byteData = 8'h00;
	cln_pkg::cln_cmd_t  cmd = '0;
	logic               cmdReady;
	logic               byteReady;
	cln_pkg::cln_pins_t pins;
	logic [5:0]         pinOe;
	logic               initDone;
	logic               cmdRefused;
	logic               evValid;
	logic               evRs;
	logic [7:0]         evData;
	logic               protErr;
	int                 n_mismatch = 0;
	int                 cmp_count = 0;
	logic [8:0]         expQ[$];
	logic [7:0]         r0;
	logic [2:0]         badLine[3] = '{3'h0, 3'h3, 3'h1};
	logic [6:0]         badPos[3] = '{7'h01, 7'h01, 7'h00};

	always #5 clk_sys = ~clk_sys;

	// line count and length stay at their defaults
	cln_writer #(.POWER_CYC(20), .WAKE_CYC(20), .SHORT_CYC(10),
		.CLEAR_CYC(20)) dut (.clk_sys(clk_sys), .srst(srst),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
		.byteValid(byteValid), .byteReady(byteReady), .byteData(byteData),
		.pins(pins), .pinOe(pinOe), .initDone(initDone),
		.cmdRefused(cmdRefused));
	cln_lcd_model lcd (.clk_sys(clk_sys), .srst(srst), .pins(pins),
		.pinOe(pinOe), .evValid(evValid), .evRs(evRs), .evData(evData),
		.protErr(protErr));

	// ==========================================================
	// shared tasks
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic pushByte(input logic [7:0] b);
		@(posedge clk_sys);
		byteValid <= 1'b1;
		byteData <= b;
		// hold the byte until the fifo has room at a sampling edge
		do
			@(posedge clk_sys);
		while (byteReady !== 1'b1);
		byteValid <= 1'b0;
	endtask

	// issue one command, watch for the refusal pulse, wait for idle
	task automatic sendCmd(input cln_pkg::cln_op_t op, input logic [2:0] ln,
		input logic [6:0] ps, input cln_pkg::cln_centre_t ce,
		input logic [7:0] cnt, input logic refuse);
		logic seen;
		int   k;
		@(posedge clk_sys);
		cmd <= '{op:op, lineNo:ln, pos:ps, centre:ce, count:cnt};
		cmdValid <= 1'b1;
		do
			@(posedge clk_sys);
		while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		seen = 1'b0;
		repeat (2)
		begin
			@(negedge clk_sys);
			seen = seen | (cmdRefused === 1'b1);
		end
		check(seen === refuse, "refusal pulse");
		k = 0;
		while (cmdReady !== 1'b1 && k < 70000)
		begin
			@(negedge clk_sys);
			k++;
		end
		check(k < 70000, "command never finished");
		repeat (2) @(negedge clk_sys);
		check(expQ.size() == 0, "transfers missing");
	endtask

	// ==========================================================
	// result watcher and watchdog
	always @(posedge clk_sys)
	begin
		if (evValid === 1'b1)
		begin
			if (expQ.size() == 0)
				check(1'b0, "extra display transfer");
			else
				check({evRs, evData} === expQ.pop_front(), "transfer");
		end
		if (protErr === 1'b1)
			check(1'b0, "pin protocol");
	end

	initial
	begin
		// the full sequence needs about 87000 cycles
		repeat (99000) @(posedge clk_sys);
		check(1'b0, "watchdog");
		summarize();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(32'h30a5));
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		check(pinOe === 6'h00 && initDone === 1'b0, "reset state");
		// fill the fifo before setup; the refused command must drain it
		repeat (8) pushByte(8'($urandom_range(0, 255)));
		@(negedge clk_sys);
		check(byteReady === 1'b0, "fifo full");
		sendCmd(cln_pkg::OP_RAW_CHAR, 3'h0, 7'h00, cln_pkg::CENTRE_NONE,
			8'h08, 1'b1);
		check(byteReady === 1'b1, "fifo drained");
		repeat (3) expQ.push_back({1'b0, cln_pkg::NIB_WAKE});
		expQ.push_back({1'b0, cln_pkg::NIB_4BIT});
		expQ.push_back({1'b0, cln_pkg::INSTR_FUNC_4BIT
			| cln_pkg::FUNC_MULTI_LINE});
		expQ.push_back({1'b0, cln_pkg::INSTR_DISPLAY_ON});
		expQ.push_back({1'b0, cln_pkg::INSTR_CLEAR});
		expQ.push_back({1'b0, cln_pkg::INSTR_ENTRY});
		sendCmd(cln_pkg::OP_DISPLAY_SETUP, 3'h0, 7'h00, cln_pkg::CENTRE_NONE,
			8'h00, 1'b0);
		check(pinOe === cln_pkg::PIN_ALL_OUT && initDone === 1'b1, "setup");
		for (int i = 0; i < 3; i++)
			sendCmd(cln_pkg::OP_TEXT, badLine[i], badPos[i],
				cln_pkg::CENTRE_NONE, 8'h00, 1'b1);
		for (int i = 0; i < 2; i++)
		begin
			r0 = 8'($urandom_range(0, 255));
			pushByte(r0);
			expQ.push_back({i[0], r0});
			sendCmd(i ? cln_pkg::OP_RAW_CHAR : cln_pkg::OP_RAW_INSTRUCTION,
				3'h0, 7'h00, cln_pkg::CENTRE_NONE, 8'h01, 1'b0);
		end
		// line 2 position 5 lands on address 40h + 4
		r0 = 8'($urandom_range(0, 255));
		pushByte(r0);
		expQ.push_back({1'b0, 8'hc4});
		expQ.push_back({1'b1, r0});
		sendCmd(cln_pkg::OP_TEXT, 3'h2, 7'h05, cln_pkg::CENTRE_NONE,
			8'h01, 1'b0);
		// one char centred in 8: blank 8 places, then start at (8-1)/2
		r0 = 8'($urandom_range(0, 255));
		pushByte(r0);
		expQ.push_back({1'b0, 8'h80});
		repeat (8) expQ.push_back({1'b1, cln_pkg::SPACE_CHAR});
		expQ.push_back({1'b0, 8'h83});
		expQ.push_back({1'b1, r0});
		sendCmd(cln_pkg::OP_TEXT, 3'h1, 7'h00, cln_pkg::CENTRE_WIDTH_8,
			8'h01, 1'b0);
		expQ.push_back({1'b0, cln_pkg::INSTR_CLEAR});
		sendCmd(cln_pkg::OP_DISPLAY_BLANK, 3'h0, 7'h00, cln_pkg::CENTRE_NONE,
			8'h00, 1'b0);
		sendCmd(cln_pkg::OP_DISPLAY_RELEASE, 3'h0, 7'h00,
			cln_pkg::CENTRE_NONE, 8'h00, 1'b0);
		check(pinOe === 6'h00 && initDone === 1'b0, "release");
		sendCmd(cln_pkg::OP_RAW_INSTRUCTION, 3'h0, 7'h00,
			cln_pkg::CENTRE_NONE, 8'h00, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
